// ### hdl/cfe_pkg.sv
// cfe_pkg: constants and carriers for the core sequencer
`default_nettype none
package cfe_pkg;
  localparam int PC_W   = 13;
  localparam int INS_W  = 14;
  localparam int DAT_W  = 8;
  localparam int DAD_W  = 9;
  localparam int FAD_W  = 7;
  localparam int JMP_W  = 11;
  localparam int PCH_W  = 5;
  localparam int GPR_N  = 224;
  localparam int GPR_AW = 8;
  // instruction field positions
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OP_HI  = 11;
  localparam int OP_LO  = 8;
  localparam int DST_B  = 7;
  localparam int PCH_JB = 3;
  localparam logic [1:0] CLS_FILE = 2'h0;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT  = 2'h3;
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR   = 4'h1;
  localparam logic [3:0] OP_MOV   = 4'h2;
  localparam logic [3:0] OP_ADD   = 4'h3;
  localparam logic [3:0] OP_SUB   = 4'h4;
  localparam logic [3:0] OP_AND   = 4'h5;
  localparam logic [3:0] OP_IOR   = 4'h6;
  localparam logic [3:0] OP_XOR   = 4'h7;
  localparam logic [3:0] OP_INC   = 4'h8;
  localparam logic [3:0] OP_DEC   = 4'h9;
  localparam logic [3:0] OP_RLF   = 4'hA;
  localparam logic [3:0] OP_RRF   = 4'hB;
  localparam logic [3:0] OP_COM   = 4'hC;
  // program space
  localparam logic [12:0] VEC_RESET = 13'h0000;
  localparam logic [12:0] VEC_IRQ   = 13'h0004;
  localparam logic [12:0] MASK_1K   = 13'h03FF;
  localparam logic [12:0] MASK_2K   = 13'h07FF;
  localparam logic [12:0] PC_ONE    = 13'h0001;
  // core registers, same offset in every bank
  localparam logic [6:0] ADR_IND    = 7'h00;
  localparam logic [6:0] ADR_PCL    = 7'h02;
  localparam logic [6:0] ADR_STATUS = 7'h03;
  localparam logic [6:0] ADR_FSR    = 7'h04;
  localparam logic [6:0] ADR_PROGRAM_COUNTER_UPPER_LATCH = 7'h0A;
  localparam logic [6:0] SFR_TOP    = 7'h1F;
  localparam int ST_IRP = 7;
  localparam int ST_RP1 = 6;
  localparam int ST_RP0 = 5;
  localparam int ST_TO  = 4;
  localparam int ST_PD  = 3;
  localparam int ST_Z   = 2;
  localparam int ST_DC  = 1;
  localparam int ST_C   = 0;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [4:0] PCH_RST    = 5'h00;
  localparam logic [7:0] FSR_RST    = 8'h00;
  localparam logic [7:0] W_RST      = 8'h00;
  // general purpose ranges and file indices
  localparam logic [8:0] G0_LO = 9'h020;
  localparam logic [8:0] G0_HI = 9'h07F;
  localparam logic [8:0] G1_LO = 9'h0A0;
  localparam logic [8:0] G1_HI = 9'h0EF;
  localparam logic [8:0] G1_BS = 9'h060;
  localparam logic [8:0] G2_LO = 9'h120;
  localparam logic [8:0] G2_HI = 9'h14F;
  localparam logic [8:0] G2_BS = 9'h0B0;
  localparam logic [6:0] CM_LO = 7'h70;
  typedef struct packed {
    logic four;
    logic three;
    logic two;
    logic one;
  } cfe_phase_t;
  localparam cfe_phase_t PH_ONE  = 4'h1;
  localparam cfe_phase_t PH_TWO  = 4'h2;
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       dc;
    logic       z;
    logic       wc;
    logic       wdc;
    logic       wz;
    logic       act;
  } cfe_alu_t;
endpackage : cfe_pkg
`default_nettype wire

// ### hdl/cfe_gpr_file.sv
// cfe_gpr_file: general purpose storage with bank and common mapping
`default_nettype none
module cfe_gpr_file (
  input  wire logic                      clock_i,
  input  wire logic                      ce_i,
  input  wire logic [cfe_pkg::DAD_W-1:0] rd_addr_i,
  output logic      [cfe_pkg::DAT_W-1:0] rd_data_o,
  input  wire logic                      wr_en_i,
  input  wire logic [cfe_pkg::DAD_W-1:0] wr_addr_i,
  input  wire logic [cfe_pkg::DAT_W-1:0] wr_data_i
);
  import cfe_pkg::*;

  logic [DAT_W-1:0]  mem [GPR_N];
  logic [GPR_AW:0]   rd_map;
  logic [GPR_AW:0]   wr_map;

  // hit bit on top, file index below
  function automatic logic [GPR_AW:0] gpr_map(input logic [DAD_W-1:0] a);
    logic [DAD_W-1:0] m;
    m = a;
    gpr_map = '0;
    if (a[FAD_W-1:0] >= CM_LO) begin
      m = {2'h0, a[FAD_W-1:0]};
    end
    if (m >= G0_LO && m <= G0_HI) begin
      gpr_map = {1'b1, GPR_AW'(m - G0_LO)};
    end else if (m >= G1_LO && m <= G1_HI) begin
      gpr_map = {1'b1, GPR_AW'(m - G1_LO + G1_BS)};
    end else if (m >= G2_LO && m <= G2_HI) begin
      gpr_map = {1'b1, GPR_AW'(m - G2_LO + G2_BS)};
    end
  endfunction : gpr_map

  always_comb begin
    rd_map = gpr_map(rd_addr_i);
    wr_map = gpr_map(wr_addr_i);
    rd_data_o = rd_map[GPR_AW] ? mem[rd_map[GPR_AW-1:0]] : 8'h00;
  end

  // unmapped writes fall away silently
  always_ff @(posedge clock_i) begin
    if (ce_i && wr_en_i && wr_map[GPR_AW]) begin
      mem[wr_map[GPR_AW-1:0]] <= wr_data_i;
    end
  end
endmodule : cfe_gpr_file
`default_nettype wire

// ### hdl/cfe_core.sv
// cfe_core: four-phase sequencer, two-stage pipeline, alu and bank map
`default_nettype none
// Functional notes
// - clock divided into four phase steps
// - pointer increments in phase one
// - fetched word latched in phase four
// - latched word executes phases two to four
// - operand read phase two, write phase four
// - fetch overlaps execute, one per cycle
// - pointer change flushes prefetch, two cycles
// - fourteen-bit instruction bus, separate data path
// - thirteen-bit instruction pointer
// - fetch address wraps into 1K or 2K
// - reset vector zero, interrupt vector four
// - two bank bits pick one of four
// - core registers in low 32 of banks
// - static storage at listed general ranges
// - top sixteen bytes alias common area
// - 224 bytes, direct or pointer addressed
// - core registers mapped, including pointer low
// - eight-bit alu add, sub, shift, logic
// - accumulator with file or literal operand
// - accumulator has no data address
// - carry, half carry, zero; borrow inverted
// - instruction rate clock in resistor mode
module cfe_core (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  input  wire logic                      mem_2k_i,
  input  wire logic                      resistor_oscillator_mode_i,
  input  wire logic                      irq_i,
  input  wire logic [cfe_pkg::INS_W-1:0] prog_data_i,
  output logic      [cfe_pkg::PC_W-1:0]  prog_addr_o,
  output cfe_pkg::cfe_phase_t            phase_o,
  output logic                           instruction_rate_clock_out_o,
  output logic                           retire_o,
  output logic      [cfe_pkg::DAT_W-1:0] result_o,
  output logic                           irq_ack_o
);
  import cfe_pkg::*;

  cfe_phase_t       phase_reg;
  logic [PC_W-1:0]  pc_reg;
  logic [PC_W-1:0]  prog_addr_reg;
  logic [PC_W-1:0]  wrap_mask;
  logic [PC_W-1:0]  new_pc;
  logic [INS_W-1:0] fetch_reg;
  logic             fetch_valid_reg;
  logic [INS_W-1:0] instr_reg;
  logic             exec_valid_reg;
  logic [DAT_W-1:0] opnd_reg;
  logic [DAT_W-1:0] w_reg;
  logic             irp_reg;
  logic [1:0]       rp_reg;
  logic             z_reg;
  logic             dc_reg;
  logic             c_reg;
  logic [DAT_W-1:0] fsr_reg;
  logic [PCH_W-1:0] pch_reg;
  logic             instruction_rate_clock_out_reg;
  logic             retire_reg;
  logic             irq_ack_reg;
  logic [DAT_W-1:0] result_reg;
  logic [1:0]       cls;
  logic [3:0]       op;
  logic             is_file;
  logic             is_lit;
  logic             dest_file;
  logic [FAD_W-1:0] fadr;
  logic [DAD_W-1:0] eff_addr;
  logic [DAT_W-1:0] status_val;
  logic [DAT_W-1:0] rd_val;
  logic [DAT_W-1:0] gpr_rd;
  logic             gpr_wr;
  cfe_alu_t         alu;
  logic             sub_op;
  logic [DAT_W-1:0] addend;
  logic [DAT_W:0]   sum;
  logic [4:0]       nib;
  logic             commit;
  logic             st_wr;
  logic             pcl_wr;
  logic             jump_x;
  logic             branch;
  logic             irq_take;

  function automatic logic is_core(
    input logic [DAD_W-1:0] a,
    input logic [FAD_W-1:0] off
  );
    is_core = (a[FAD_W-1:0] == off);
  endfunction : is_core

  // phase ring; oscillator steps are clock_i edges with ce_i high
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_reg <= PH_ONE;
    end else if (ce_i) begin
      phase_reg <= cfe_phase_t'({phase_reg.three, phase_reg.two,
                                 phase_reg.one, phase_reg.four});
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pc_reg <= VEC_RESET;
    end else if (ce_i) begin
      if (phase_reg.one) begin
        pc_reg <= pc_reg + PC_ONE;
      end else if (branch) begin
        pc_reg <= new_pc;
      end else if (irq_take) begin
        pc_reg <= VEC_IRQ;
      end
    end
  end

  assign wrap_mask = mem_2k_i ? MASK_2K : MASK_1K;

  // only the fetch address is wrapped, the pointer keeps all 13 bits
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prog_addr_reg <= VEC_RESET;
    end else if (ce_i && phase_reg.one) begin
      prog_addr_reg <= pc_reg & wrap_mask;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fetch_reg       <= '0;
      fetch_valid_reg <= 1'b0;
    end else if (ce_i && phase_reg.four) begin
      fetch_reg       <= prog_data_i;
      fetch_valid_reg <= !(branch || irq_take);
    end
  end

  // next fetch runs while this one executes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      instr_reg      <= '0;
      exec_valid_reg <= 1'b0;
    end else if (ce_i && phase_reg.one) begin
      instr_reg      <= fetch_reg;
      exec_valid_reg <= fetch_valid_reg;
    end
  end

  always_comb begin
    cls       = instr_reg[CLS_HI:CLS_LO];
    op        = instr_reg[OP_HI:OP_LO];
    is_file   = (cls == CLS_FILE);
    is_lit    = (cls == CLS_LIT);
    dest_file = is_file && (instr_reg[DST_B] || op == OP_MOVWF);
    fadr      = instr_reg[FAD_W-1:0];
    if (fadr == ADR_IND) begin
      eff_addr = {irp_reg, fsr_reg};
    end else begin
      eff_addr = {rp_reg, fadr};
    end
  end

  assign status_val = {irp_reg, rp_reg, STATUS_RST[ST_TO],
                       STATUS_RST[ST_PD], z_reg, dc_reg, c_reg};

  // other low-area slots belong to peripherals and read zero here
  always_comb begin
    if (is_core(eff_addr, ADR_PCL)) begin
      rd_val = prog_addr_reg[DAT_W-1:0];
    end else if (is_core(eff_addr, ADR_STATUS)) begin
      rd_val = status_val;
    end else if (is_core(eff_addr, ADR_FSR)) begin
      rd_val = fsr_reg;
    end else if (is_core(eff_addr, ADR_PROGRAM_COUNTER_UPPER_LATCH)) begin
      rd_val = {3'h0, pch_reg};
    end else if (eff_addr[FAD_W-1:0] <= SFR_TOP) begin
      rd_val = 8'h00;
    end else begin
      rd_val = gpr_rd;
    end
  end

  // subtraction is opnd + ~w + 1, so carry is an inverted borrow
  always_comb begin
    alu     = '0;
    alu.act = 1'b1;
    sub_op  = (op == OP_SUB);
    addend  = sub_op ? ~w_reg : w_reg;
    sum     = {1'b0, opnd_reg} + {1'b0, addend} + {8'h00, sub_op};
    nib     = {1'b0, opnd_reg[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_op};
    unique case (op)
      OP_MOVWF: alu.res = w_reg;
      OP_CLR: begin
        alu.res = 8'h00;
        alu.wz  = 1'b1;
      end
      OP_MOV: begin
        alu.res = opnd_reg;
        alu.wz  = !is_lit;
      end
      OP_ADD, OP_SUB: begin
        alu.res = sum[DAT_W-1:0];
        alu.c   = sum[DAT_W];
        alu.dc  = nib[4];
        alu.wc  = 1'b1;
        alu.wdc = 1'b1;
        alu.wz  = 1'b1;
      end
      OP_AND: begin
        alu.res = opnd_reg & w_reg;
        alu.wz  = 1'b1;
      end
      OP_IOR: begin
        alu.res = opnd_reg | w_reg;
        alu.wz  = 1'b1;
      end
      OP_XOR: begin
        alu.res = opnd_reg ^ w_reg;
        alu.wz  = 1'b1;
      end
      OP_INC: begin
        alu.res = opnd_reg + 8'h01;
        alu.wz  = 1'b1;
      end
      OP_DEC: begin
        alu.res = opnd_reg - 8'h01;
        alu.wz  = 1'b1;
      end
      OP_RLF: begin
        alu.res = {opnd_reg[DAT_W-2:0], c_reg};
        alu.c   = opnd_reg[DAT_W-1];
        alu.wc  = 1'b1;
      end
      OP_RRF: begin
        alu.res = {c_reg, opnd_reg[DAT_W-1:1]};
        alu.c   = opnd_reg[0];
        alu.wc  = 1'b1;
      end
      OP_COM: begin
        alu.res = ~opnd_reg;
        alu.wz  = 1'b1;
      end
      default: alu.act = 1'b0;
    endcase
    alu.z = (alu.res == 8'h00);
  end

  always_comb begin
    commit   = phase_reg.four && exec_valid_reg && (is_file || is_lit) && alu.act;
    st_wr    = commit && dest_file && is_core(eff_addr, ADR_STATUS);
    pcl_wr   = commit && dest_file && is_core(eff_addr, ADR_PCL);
    gpr_wr   = commit && dest_file && (eff_addr[FAD_W-1:0] > SFR_TOP);
    jump_x   = phase_reg.four && exec_valid_reg && (cls == CLS_JUMP);
    branch   = jump_x || pcl_wr;
    irq_take = phase_reg.four && irq_i && !branch;
    if (jump_x) begin
      new_pc = {pch_reg[PCH_W-1:PCH_JB], instr_reg[JMP_W-1:0]};
    end else begin
      new_pc = {pch_reg, alu.res};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      opnd_reg <= 8'h00;
    end else if (ce_i && phase_reg.two) begin
      opnd_reg <= is_lit ? instr_reg[DAT_W-1:0] : rd_val;
    end
  end

  // accumulator lives only here, never on the data address map
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      w_reg <= W_RST;
    end else if (ce_i && commit && !dest_file) begin
      w_reg <= alu.res;
    end
  end

  // alu flags beat a plain write of the same bits
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irp_reg <= STATUS_RST[ST_IRP];
      rp_reg  <= {STATUS_RST[ST_RP1], STATUS_RST[ST_RP0]};
      z_reg   <= STATUS_RST[ST_Z];
      dc_reg  <= STATUS_RST[ST_DC];
      c_reg   <= STATUS_RST[ST_C];
    end else if (ce_i && commit) begin
      if (st_wr) begin
        irp_reg <= alu.res[ST_IRP];
        rp_reg  <= {alu.res[ST_RP1], alu.res[ST_RP0]};
      end
      if (alu.wz) begin
        z_reg <= alu.z;
      end else if (st_wr) begin
        z_reg <= alu.res[ST_Z];
      end
      if (alu.wdc) begin
        dc_reg <= alu.dc;
      end else if (st_wr) begin
        dc_reg <= alu.res[ST_DC];
      end
      if (alu.wc) begin
        c_reg <= alu.c;
      end else if (st_wr) begin
        c_reg <= alu.res[ST_C];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fsr_reg <= FSR_RST;
      pch_reg <= PCH_RST;
    end else if (ce_i && commit && dest_file) begin
      if (is_core(eff_addr, ADR_FSR)) begin
        fsr_reg <= alu.res;
      end
      if (is_core(eff_addr, ADR_PROGRAM_COUNTER_UPPER_LATCH)) begin
        pch_reg <= alu.res[PCH_W-1:0];
      end
    end
  end

  cfe_gpr_file u_gpr (
    .clock_i   (clock_i),
    .ce_i      (ce_i),
    .rd_addr_i (eff_addr),
    .rd_data_o (gpr_rd),
    .wr_en_i   (gpr_wr),
    .wr_addr_i (eff_addr),
    .wr_data_i (alu.res)
  );

  // high for phases one and two, low for three and four
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      instruction_rate_clock_out_reg <= 1'b0;
    end else if (ce_i) begin
      instruction_rate_clock_out_reg <= resistor_oscillator_mode_i &&
                    (phase_reg.four || phase_reg.one);
    end
  end

  // pulses freeze along with everything else while ce_i is low
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      retire_reg  <= 1'b0;
      irq_ack_reg <= 1'b0;
      result_reg  <= 8'h00;
    end else if (ce_i) begin
      retire_reg  <= phase_reg.four && exec_valid_reg;
      irq_ack_reg <= irq_take;
      if (commit) begin
        result_reg <= alu.res;
      end
    end
  end

  assign phase_o                      = phase_reg;
  assign prog_addr_o                  = prog_addr_reg;
  assign instruction_rate_clock_out_o = instruction_rate_clock_out_reg;
  assign retire_o                     = retire_reg;
  assign irq_ack_o                    = irq_ack_reg;
  assign result_o                     = result_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  phase_ring_a: assert property (
    ce_i && phase_reg.one ##1 ce_i [*3] |=> phase_reg == PH_ONE)
    else $error("phase ring not four steps");

  phase_next_a: assert property (
    ce_i && phase_reg.one |=> phase_reg == PH_TWO)
    else $error("phase one not followed by two");

  pc_step_a: assert property (
    ce_i && phase_reg.one |=> pc_reg == $past(pc_reg) + PC_ONE)
    else $error("pointer did not step in phase one");

  fetch_take_a: assert property (
    ce_i && phase_reg.four |=> fetch_reg == $past(prog_data_i))
    else $error("fetch word not latched in phase four");

  exec_take_a: assert property (
    ce_i && phase_reg.one |=> instr_reg == $past(fetch_reg) &&
                             exec_valid_reg == $past(fetch_valid_reg))
    else $error("latched word not moved to execute");

  flush_a: assert property (
    ce_i && branch ##1 ce_i |=> !exec_valid_reg)
    else $error("prefetched word not discarded");

  wrap_a: assert property (
    ce_i && phase_reg.one |=>
      prog_addr_reg == ($past(pc_reg) & $past(wrap_mask)))
    else $error("fetch address not wrapped");

  reset_vec_a: assert property (
    $past(rst_i) |-> pc_reg == VEC_RESET && !fetch_valid_reg &&
                     !exec_valid_reg)
    else $error("reset did not empty pipeline");

  irq_vec_a: assert property (
    ce_i && irq_take |=> pc_reg == VEC_IRQ && irq_ack_o)
    else $error("interrupt did not vector");

  borrow_a: assert property (
    ce_i && commit && sub_op |=>
      c_reg == ($past(opnd_reg) >= $past(w_reg)))
    else $error("subtract carry not inverted borrow");

  instruction_rate_clock_out_a: assert property (
    ce_i && phase_reg.two |=> !instruction_rate_clock_out_o)
    else $error("rate clock high in phase three");
endmodule : cfe_core
`default_nettype wire

// ### bench/cfe_prog_mem.sv
// cfe_prog_mem: behavioural program memory answering the core's fetch address
`default_nettype none
module cfe_prog_mem (
  input  wire logic [cfe_pkg::PC_W-1:0]  addr_i,
  output logic      [cfe_pkg::INS_W-1:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import cfe_pkg::*;
  logic [INS_W-1:0] word_mem [0:2047];
  // combinational, 2K deep: only the low eleven address bits are decoded
  assign data_o = word_mem[addr_i[10:0]];
endmodule : cfe_prog_mem
`default_nettype wire

// ### bench/tb_core_fetch_execute_and_bank_map.sv
// tb_core_fetch_execute_and_bank_map: self-checking bench with a step model of the core
`default_nettype none
module tb_core_fetch_execute_and_bank_map;
  timeunit 1ns;
  timeprecision 100ps;
  import cfe_pkg::*;
  logic              clock_i;
  logic              rst_i;
  logic              ce_i;
  logic              mem_2k_i;
  logic              resistor_oscillator_mode_i;
  logic              irq_i;
  logic [INS_W-1:0]  prog_data;
  logic [PC_W-1:0]   prog_addr_o;
  cfe_phase_t        phase_o;
  logic              instruction_rate_clock_out_o;
  logic              retire_o;
  logic [DAT_W-1:0]  result_o;
  logic              irq_ack_o;
  int                err_count;
  int                n_compared;
  int                n;
  int                nret;
  int                cycles;
  int                irq_at;
  int                ack_exp;
  bit                fresh;
  bit                active;
  logic [12:0]       fetch_q [$];
  int                ret_q [$];
  logic [7:0]        res_q [$];

  cfe_core DUT (
    .clock_i                      (clock_i),
    .rst_i                        (rst_i),
    .ce_i                         (ce_i),
    .mem_2k_i                     (mem_2k_i),
    .resistor_oscillator_mode_i   (resistor_oscillator_mode_i),
    .irq_i                        (irq_i),
    .prog_data_i                  (prog_data),
    .prog_addr_o                  (prog_addr_o),
    .phase_o                      (phase_o),
    .instruction_rate_clock_out_o (instruction_rate_clock_out_o),
    .retire_o                     (retire_o),
    .result_o                     (result_o),
    .irq_ack_o                    (irq_ack_o)
  );

  cfe_prog_mem u_mem (
    .addr_i (prog_addr_o),
    .data_o (prog_data)
  );

  always #12.5 clock_i = ~clock_i;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [13:0] lit(input logic [3:0] op, input logic [7:0] k);
    return {CLS_LIT, op, k};
  endfunction : lit

  // program image and expected trace; cycle c retires at ce edge 4c+4
  task automatic model(input logic m2k);
    logic [12:0] mask;
    logic [12:0] pc;
    logic [12:0] cur;
    logic [13:0] ins;
    logic [7:0]  w;
    logic [7:0]  res;
    logic [7:0]  com [0:15];
    logic [6:0]  cf;
    int          cyc;
    bit          brk;
    mask = m2k ? MASK_2K : MASK_1K;
    cf = CM_LO + 7'($urandom_range(15));
    for (int i = 0; i < 2048; i++) u_mem.word_mem[i] = 14'h1000;
    u_mem.word_mem[0] = lit(OP_MOV, 8'($urandom));
    u_mem.word_mem[1] = lit(OP_ADD, 8'($urandom));
    u_mem.word_mem[2] = {CLS_FILE, OP_MOVWF, 1'b1, cf};
    u_mem.word_mem[3] = lit(OP_MOV, 8'h60);
    u_mem.word_mem[4] = {CLS_FILE, OP_MOVWF, 1'b1, ADR_STATUS};
    u_mem.word_mem[5] = {CLS_FILE, OP_MOV, 1'b0, cf};
    u_mem.word_mem[6] = lit(OP_XOR, 8'($urandom));
    u_mem.word_mem[7] = {CLS_JUMP, 1'b0, 11'h7F0};
    u_mem.word_mem[11'h3F0] = lit(OP_IOR, 8'($urandom));
    u_mem.word_mem[11'h7F0] = lit(OP_AND, 8'($urandom));
    u_mem.word_mem[11'h3F1] = lit(OP_SUB, 8'($urandom));
    u_mem.word_mem[11'h7F1] = u_mem.word_mem[11'h3F1];
    u_mem.word_mem[11'h3F2] = {CLS_FILE, OP_MOV, 1'b0, ADR_PCL};
    u_mem.word_mem[11'h7F2] = u_mem.word_mem[11'h3F2];
    u_mem.word_mem[11'h3F3] = {CLS_JUMP, 12'h000};
    u_mem.word_mem[11'h7F3] = {CLS_JUMP, 12'h000};
    fetch_q.delete();
    ret_q.delete();
    res_q.delete();
    fetch_q.push_back(VEC_RESET);
    pc = PC_ONE;
    cur = VEC_RESET;
    cyc = 1;
    w = W_RST;
    res = 8'h00;
    ack_exp = 0;
    for (int s = 0; s < 20; s++) begin
      ins = u_mem.word_mem[cur[10:0]];
      fetch_q.push_back(pc & mask);
      brk = 1'b0;
      case (ins[13:12])
        CLS_LIT: begin
          case (ins[11:8])
            OP_MOV:  w = ins[7:0];
            OP_ADD:  w = w + ins[7:0];
            OP_SUB:  w = ins[7:0] - w;
            OP_AND:  w = w & ins[7:0];
            OP_IOR:  w = w | ins[7:0];
            default: w = w ^ ins[7:0];
          endcase
          res = w;
        end
        CLS_FILE: begin
          // every bank's top sixteen bytes land in one common array
          if (ins[11:8] == OP_MOVWF && ins[6:0] != ADR_STATUS) com[ins[3:0]] = w;
          // the low pointer byte reads back the fetch address of this cycle
          if (ins[11:8] == OP_MOV) w = (ins[6:0] == ADR_PCL) ? 8'(pc & mask) : com[ins[3:0]];
          res = w;
        end
        CLS_JUMP: begin
          brk = 1'b1;
          pc = {2'b00, ins[10:0]};
        end
        default: ;
      endcase
      ret_q.push_back(4 * cyc + 4);
      res_q.push_back(res);
      if (s == irq_at) begin
        brk = 1'b1;
        pc = VEC_IRQ;
        ack_exp = 4 * cyc + 4;
      end
      cyc++;
      if (brk) begin
        fetch_q.push_back(pc & mask);
        cyc++;
      end
      cur = pc & mask;
      pc = pc + PC_ONE;
    end
  endtask : model

  task automatic run(input logic m2k, input logic md, input int irq_step);
    @(negedge clock_i);
    active = 1'b0;
    rst_i = 1'b1;
    irq_at = irq_step;
    model(m2k);
    mem_2k_i = m2k;
    resistor_oscillator_mode_i = md;
    repeat (8) @(negedge clock_i);
    nret = 0;
    rst_i = 1'b0;
    active = 1'b1;
    for (int i = 0; i < 2000 && ret_q.size() != 0; i++) @(negedge clock_i);
    active = 1'b0;
    check(16'(ret_q.size()), 16'h0000, "missing retires");
    check(16'(ack_exp), 16'h0000, "interrupt ack missing");
  endtask : run

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      tally_and_finish();
    end
    fresh = ce_i && !rst_i;
    if (rst_i) n = 0;
    else if (ce_i) n++;
  end

  // stalls come from ce_i; checks run only after an edge that advanced the core
  always @(negedge clock_i) begin
    ce_i <= !active || ($urandom_range(7) != 0);
    if (active && fresh) begin
      check(16'(phase_o), 16'(4'h1 << (n % 4)), "phase");
      check(16'(instruction_rate_clock_out_o), 16'(resistor_oscillator_mode_i && (n % 4) < 2), "rate clock");
      if (n % 4 == 1 && fetch_q.size() != 0) check(16'(prog_addr_o), 16'(fetch_q.pop_front()), "fetch");
      if (retire_o === 1'b1 && ret_q.size() != 0) begin
        check(16'(n), 16'(ret_q.pop_front()), "retire edge");
        check(16'(result_o), 16'(res_q.pop_front()), "result");
        nret++;
        if (nret == irq_at) irq_i <= 1'b1;
      end
      if (irq_ack_o === 1'b1) begin
        check(16'(n), 16'(ack_exp), "interrupt ack");
        ack_exp = 0;
        irq_i <= 1'b0;
      end
    end
  end

  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    mem_2k_i = 1'b0;
    resistor_oscillator_mode_i = 1'b0;
    irq_i = 1'b0;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
    irq_at = -1;
    active = 1'b0;
    void'($urandom(32'h1d6d));
    run(1'b0, 1'b1, 3);
    run(1'b1, 1'b0, -1);
    tally_and_finish();
  end
endmodule : tb_core_fetch_execute_and_bank_map
`default_nettype wire
